// [hw/dif_top.sv]
// Function
// - Three weighted ramp inputs form a code choosing one of eight ramp pairs.
// - Dc_injection_brake input applies configured DC level while stopping or stopped.
// - Second motor set follows its input only while the drive is stopped.
// - Exchange input moves motor between drive and line relays with speed search.
// - Both relays stay open 500 ms before closing the other one.
// - Up/down pulses step the speed reference, clamped to maximum frequency.
// - Three-wire mode latches run on start pulse, clears on stop opening.
// - External trip cuts output and flags fault; polarity selectable.
// - Pre-heat input applies the low configured DC current.
// - Integrator clear input forces the PID integral to zero.
// - Open-loop input switches from PID mode, accepted only while stopped.
// - Local/remote input picks remote or local command and frequency sources.
// - Hold input freezes output frequency when an analog reference is used.
// - Ramp hold input stops acceleration and deceleration.
// - Alternate gain input selects the second PID proportional gain.
// - Multi-motor interlock forces first four inputs to interlock functions.
// - Fault reset acts on the closure edge, not the held level.
// - Output disable latches until manual reset; polarity programmable.
// - Source change input selects current input under combined reference.
// - Outer PID runs only while its run input is on.
// - Each monitor output scales quantity over full scale times gain/100.
// - Two terminals on one function raise a duplicate flag.
`timescale 1ns/1ps
module dif_top #(
  parameter int unsigned CYC_PER_MS    = dif_pkg::MS_CYC,
  parameter int unsigned INTERLOCK_CYC = dif_pkg::INTERLOCK_CYC
) (
  input  wire logic                      clk_sys,
  input  wire logic                      arst_n,
  input  wire logic [7:0]                term_pin,
  input  wire logic [7:0]                term_nc_mask,
  input  wire logic [7:0][4:0]           term_func,
  input  wire logic [7:0]                filter_ms,
  input  wire logic                      mmc_interlock_en,
  input  wire logic                      drive_stopped,
  input  wire logic                      drive_stopping,
  input  wire logic                      three_wire_mode,
  input  wire logic                      analog_ref_sel,
  input  wire logic                      combo_ref_sel,
  input  wire logic [7:0]                dc_injection_brake_level,
  input  wire logic [7:0]                preheat_level,
  input  wire logic [15:0]               max_freq,
  input  wire logic [15:0]               updown_step,
  input  wire logic [1:0][15:0]          mon_quantity,
  input  wire logic [1:0][15:0]          mon_full_scale,
  input  wire logic [1:0][7:0]           mon_gain,
  output logic      [2:0]                ramp_set,
  output logic                           dc_injection_brake,
  output logic      [7:0]                dc_level,
  output logic                           motor2_sel,
  output logic                           drive_side_relay,
  output logic                           line_side_relay,
  output logic                           speed_search_setting,
  output logic      [15:0]               speed_ref,
  output logic                           run_cmd,
  output logic                           ext_fault,
  output logic                           output_disable,
  output logic                           output_cut,
  output logic                           fault_clear,
  output logic                           preheat_on,
  output logic                           integrator_clear,
  output logic                           open_loop,
  output logic                           local_remote_sel,
  output logic                           freq_freeze,
  output logic                           ramp_hold,
  output logic                           pgain2_sel,
  output logic      [3:0]                interlock,
  output logic                           current_ref_sel,
  output logic                           outer_pid_run,
  output logic                           dup_assign,
  output logic      [9:0]                monitor_out_a,
  output logic      [9:0]                monitor_out_b
);

  localparam int NT = dif_pkg::NTERM;
  localparam int NF = dif_pkg::NFUNC;

  logic [NT-1:0]                    sync1_reg;
  logic [NT-1:0]                    sync2_reg;
  logic [NT-1:0]                    deb_reg;
  logic [NT-1:0]                    lvl;
  logic [dif_pkg::MSCNT_W-1:0]      ms_cnt_reg;
  logic                             ms_tick_reg;
  logic [NT-1:0][dif_pkg::FUNC_W-1:0] sel_eff;
  logic [NF-1:0]                    fa;
  logic                             dup_next;
  logic                             up_prev_reg;
  logic                             dn_prev_reg;
  logic                             fwd_prev_reg;
  logic                             rst_prev_reg;
  logic                             rst_edge;
  logic                             run_latch_reg;
  logic [16:0]                      up_sum;
  dif_pkg::dif_xchg_t               xs_reg;
  logic [dif_pkg::XTMR_W-1:0]       xtmr_reg;
  logic                             xtmr_done;
  logic [1:0]                       prime_reg;
  logic                             primed;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= term_pin;
      sync2_reg <= sync1_reg;
    end
  end

  // The filters load the settled pin level once after reset, so that a
  // normally-closed input does not read as active while its filter counts.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prime_reg <= '0;
    end else if (!primed) begin
      prime_reg <= prime_reg + 2'h1;
    end
  end

  assign primed = (prime_reg == 2'h3);

  // ****************************************
  // Millisecond tick for the input filter
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ms_cnt_reg  <= '0;
      ms_tick_reg <= 1'b0;
    end else if (ms_cnt_reg == dif_pkg::MSCNT_W'(CYC_PER_MS - 1)) begin
      ms_cnt_reg  <= '0;
      ms_tick_reg <= 1'b1;
    end else begin
      ms_cnt_reg  <= ms_cnt_reg + 1'b1;
      ms_tick_reg <= 1'b0;
    end
  end

  // ****************************************
  // Per-terminal debounce and polarity
  // ****************************************
  // A new level is taken once it has held for the filter time in ms.
  for (genvar i = 0; i < NT; i++) begin : g_term
    logic [dif_pkg::FILT_W-1:0] cnt_reg;
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        cnt_reg    <= '0;
        deb_reg[i] <= 1'b0;
      end else if (!primed) begin
        deb_reg[i] <= sync2_reg[i];
        cnt_reg    <= '0;
      end else if (sync2_reg[i] == deb_reg[i]) begin
        cnt_reg <= '0;
      end else if (ms_tick_reg) begin
        if (cnt_reg >= filter_ms) begin
          deb_reg[i] <= sync2_reg[i];
          cnt_reg    <= '0;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
    assign lvl[i] = (deb_reg[i] ^ term_nc_mask[i]) & primed;
    // Interlock takes over the first four terminals when enabled.
    if (i < dif_pkg::NLOCK) begin : g_lock
      assign sel_eff[i] = mmc_interlock_en
                        ? dif_pkg::FUNC_W'(dif_pkg::FN_INTERLOCK1 + i)
                        : term_func[i];
    end else begin : g_free
      assign sel_eff[i] = term_func[i];
    end
  end

  // ****************************************
  // Function decode and duplicate check
  // ****************************************
  always_comb begin
    fa       = '0;
    dup_next = 1'b0;
    for (int t = 0; t < NT; t++) begin
      for (int f = 1; f < NF; f++) begin
        if (sel_eff[t] == dif_pkg::FUNC_W'(f)) begin
          fa[f] = fa[f] | lvl[t];
        end
      end
      for (int u = t + 1; u < NT; u++) begin
        if (sel_eff[t] != dif_pkg::FN_NONE && sel_eff[t] == sel_eff[u]) begin
          dup_next = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dup_assign <= 1'b0;
    end else begin
      dup_assign <= dup_next;
    end
  end

  // ****************************************
  // Ramp selection and level functions
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ramp_set         <= '0;
      ramp_hold        <= 1'b0;
      integrator_clear <= 1'b0;
      pgain2_sel       <= 1'b0;
      local_remote_sel <= 1'b0;
      outer_pid_run    <= 1'b0;
      interlock        <= '0;
      freq_freeze      <= 1'b0;
      current_ref_sel  <= 1'b0;
    end else begin
      ramp_set <= {fa[dif_pkg::FN_RAMP_SEL_HIGH],
                   fa[dif_pkg::FN_RAMP_SEL_MID],
                   fa[dif_pkg::FN_RAMP_SEL_LOW]};
      ramp_hold        <= fa[dif_pkg::FN_RAMP_HOLD];
      integrator_clear <= fa[dif_pkg::FN_INTEG_CLEAR];
      pgain2_sel       <= fa[dif_pkg::FN_PGAIN2];
      local_remote_sel <= fa[dif_pkg::FN_LOCAL_REMOTE];
      outer_pid_run    <= fa[dif_pkg::FN_OUTER_PID_RUN];
      interlock <= fa[dif_pkg::FN_INTERLOCK4:dif_pkg::FN_INTERLOCK1];
      freq_freeze <= fa[dif_pkg::FN_ANALOG_HOLD] & analog_ref_sel;
      current_ref_sel <= fa[dif_pkg::FN_ANA_CHANGE] & combo_ref_sel;
    end
  end

  // ****************************************
  // Stopped-only mode switches
  // ****************************************
  // Requests made while running wait until the drive stops.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      motor2_sel <= 1'b0;
      open_loop  <= 1'b0;
    end else if (drive_stopped) begin
      motor2_sel <= fa[dif_pkg::FN_MOTOR2];
      open_loop  <= fa[dif_pkg::FN_OPEN_LOOP];
    end
  end

  // ****************************************
  // DC injection and pre-heat
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dc_injection_brake <= 1'b0;
      preheat_on         <= 1'b0;
      dc_level           <= dif_pkg::LVL_OFF;
    end else begin
      dc_injection_brake <= fa[dif_pkg::FN_DC_INJECTION_BRAKE]
                          & (drive_stopped | drive_stopping);
      preheat_on <= fa[dif_pkg::FN_PREHEAT];
      if (fa[dif_pkg::FN_DC_INJECTION_BRAKE] && (drive_stopped || drive_stopping)) begin
        dc_level <= dc_injection_brake_level;
      end else if (fa[dif_pkg::FN_PREHEAT]) begin
        dc_level <= preheat_level;
      end else begin
        dc_level <= dif_pkg::LVL_OFF;
      end
    end
  end

  // ****************************************
  // Edge history
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      up_prev_reg  <= 1'b0;
      dn_prev_reg  <= 1'b0;
      fwd_prev_reg <= 1'b0;
      rst_prev_reg <= 1'b0;
    end else begin
      up_prev_reg  <= fa[dif_pkg::FN_UP];
      dn_prev_reg  <= fa[dif_pkg::FN_DOWN];
      fwd_prev_reg <= fa[dif_pkg::FN_FORWARD_RUN];
      rst_prev_reg <= fa[dif_pkg::FN_FAULT_RESET];
    end
  end

  assign rst_edge = fa[dif_pkg::FN_FAULT_RESET] & ~rst_prev_reg;
  assign up_sum   = {1'b0, speed_ref} + {1'b0, updown_step};

  // ****************************************
  // Up/down speed reference
  // ****************************************
  // Simultaneous up and down presses cancel.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      speed_ref <= dif_pkg::FREQ_RST;
    end else if (fa[dif_pkg::FN_UP] && !up_prev_reg && !fa[dif_pkg::FN_DOWN]) begin
      if (up_sum > {1'b0, max_freq}) begin
        speed_ref <= max_freq;
      end else begin
        speed_ref <= up_sum[15:0];
      end
    end else if (fa[dif_pkg::FN_DOWN] && !dn_prev_reg && !fa[dif_pkg::FN_UP]) begin
      if (speed_ref < updown_step) begin
        speed_ref <= dif_pkg::FREQ_RST;
      end else begin
        speed_ref <= speed_ref - updown_step;
      end
    end else if (speed_ref > max_freq) begin
      speed_ref <= max_freq;
    end
  end

  // ****************************************
  // Run command and three-wire latch
  // ****************************************
  // The stop button is closed at rest; opening it clears the latch.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_latch_reg <= 1'b0;
    end else if (!fa[dif_pkg::FN_THREE_WIRE]) begin
      run_latch_reg <= 1'b0;
    end else if (fa[dif_pkg::FN_FORWARD_RUN] && !fwd_prev_reg) begin
      run_latch_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_cmd <= 1'b0;
    end else if (three_wire_mode) begin
      run_cmd <= run_latch_reg;
    end else begin
      run_cmd <= fa[dif_pkg::FN_FORWARD_RUN];
    end
  end

  // ****************************************
  // Trip, disable and fault reset
  // ****************************************
  // An active trip or disable outranks a reset in the same cycle.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ext_fault <= 1'b0;
    end else if (fa[dif_pkg::FN_EXT_TRIP]) begin
      ext_fault <= 1'b1;
    end else if (rst_edge) begin
      ext_fault <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      output_disable <= 1'b0;
    end else if (fa[dif_pkg::FN_OUT_DISABLE]) begin
      output_disable <= 1'b1;
    end else if (rst_edge) begin
      output_disable <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      output_cut  <= 1'b0;
      fault_clear <= 1'b0;
    end else begin
      output_cut <= fa[dif_pkg::FN_EXT_TRIP] | fa[dif_pkg::FN_OUT_DISABLE]
                  | ext_fault | output_disable;
      fault_clear <= rst_edge;
    end
  end

  // ****************************************
  // Line exchange sequencer
  // ****************************************
  assign xtmr_done = (xtmr_reg == dif_pkg::XTMR_W'(INTERLOCK_CYC - 1));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      xs_reg   <= dif_pkg::XS_DRIVE;
      xtmr_reg <= '0;
    end else begin
      unique case (xs_reg)
        dif_pkg::XS_DRIVE: begin
          xtmr_reg <= '0;
          if (fa[dif_pkg::FN_EXCHANGE]) begin
            xs_reg <= dif_pkg::XS_GAP_LINE;
          end
        end
        dif_pkg::XS_GAP_LINE: begin
          xtmr_reg <= xtmr_reg + 1'b1;
          if (xtmr_done) begin
            xs_reg <= dif_pkg::XS_LINE;
          end
        end
        dif_pkg::XS_LINE: begin
          xtmr_reg <= '0;
          if (!fa[dif_pkg::FN_EXCHANGE]) begin
            xs_reg <= dif_pkg::XS_GAP_DRV;
          end
        end
        dif_pkg::XS_GAP_DRV: begin
          xtmr_reg <= xtmr_reg + 1'b1;
          if (xtmr_done) begin
            xs_reg <= dif_pkg::XS_DRIVE;
          end
        end
      endcase
    end
  end

  // Both relays are open in the gap states.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      drive_side_relay     <= 1'b0;
      line_side_relay      <= 1'b0;
      speed_search_setting <= 1'b0;
    end else begin
      drive_side_relay     <= (xs_reg == dif_pkg::XS_DRIVE);
      line_side_relay      <= (xs_reg == dif_pkg::XS_LINE);
      speed_search_setting <= (xs_reg != dif_pkg::XS_DRIVE);
    end
  end

  // ****************************************
  // Monitor outputs
  // ****************************************
  dif_mon_if mon_bus [dif_pkg::NMON] ();

  for (genvar m = 0; m < dif_pkg::NMON; m++) begin : g_mon
    assign mon_bus[m].quantity   = mon_quantity[m];
    assign mon_bus[m].full_scale = mon_full_scale[m];
    assign mon_bus[m].gain       = mon_gain[m];
    dif_mon_scale u_scale (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .mon     (mon_bus[m])
    );
  end

  assign monitor_out_a = mon_bus[0].code;
  assign monitor_out_b = mon_bus[1].code;

endmodule

// [hw/dif_pkg.sv]
package dif_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_CYC        = CLK_HZ / MS_PER_S;
  localparam int unsigned INTERLOCK_MS  = 500;
  localparam int unsigned INTERLOCK_CYC = INTERLOCK_MS * MS_CYC;

  // ****************************************
  // Widths
  // ****************************************
  localparam int NTERM   = 8;
  localparam int NLOCK   = 4;
  localparam int NMON    = 2;
  localparam int FUNC_W  = 5;
  localparam int FREQ_W  = 16;
  localparam int GAIN_W  = 8;
  localparam int DAC_W   = 10;
  localparam int FILT_W  = 8;
  localparam int MSCNT_W = 18;
  localparam int XTMR_W  = 27;
  localparam int LVL_W   = 8;

  // ****************************************
  // Scaling and reset values
  // ****************************************
  localparam logic [DAC_W-1:0]  DAC_FULL   = 10'h3FF;
  localparam logic [7:0]        GAIN_DIV   = 8'h64;
  localparam logic [FREQ_W-1:0] FREQ_RST   = 16'h0000;
  localparam logic [LVL_W-1:0]  LVL_OFF    = 8'h00;

  // ****************************************
  // Terminal functions
  // ****************************************
  typedef enum logic [FUNC_W-1:0] {
    FN_NONE          = 5'h00,
    FN_RAMP_SEL_LOW  = 5'h01,
    FN_RAMP_SEL_MID  = 5'h02,
    FN_RAMP_SEL_HIGH = 5'h03,
    FN_DC_INJECTION_BRAKE      = 5'h04,
    FN_MOTOR2        = 5'h05,
    FN_EXCHANGE      = 5'h06,
    FN_UP            = 5'h07,
    FN_DOWN          = 5'h08,
    FN_THREE_WIRE    = 5'h09,
    FN_EXT_TRIP      = 5'h0A,
    FN_PREHEAT       = 5'h0B,
    FN_INTEG_CLEAR   = 5'h0C,
    FN_OPEN_LOOP     = 5'h0D,
    FN_LOCAL_REMOTE  = 5'h0E,
    FN_ANALOG_HOLD   = 5'h0F,
    FN_RAMP_HOLD     = 5'h10,
    FN_PGAIN2        = 5'h11,
    FN_INTERLOCK1    = 5'h12,
    FN_INTERLOCK2    = 5'h13,
    FN_INTERLOCK3    = 5'h14,
    FN_INTERLOCK4    = 5'h15,
    FN_FAULT_RESET   = 5'h16,
    FN_OUT_DISABLE   = 5'h17,
    FN_FORWARD_RUN   = 5'h18,
    FN_ANA_CHANGE    = 5'h19,
    FN_OUTER_PID_RUN = 5'h1A
  } dif_func_t;

  localparam int NFUNC = 27;

  // ****************************************
  // Line exchange states
  // ****************************************
  typedef enum logic [1:0] {
    XS_DRIVE    = 2'b00,
    XS_GAP_LINE = 2'b01,
    XS_LINE     = 2'b11,
    XS_GAP_DRV  = 2'b10
  } dif_xchg_t;

endpackage

// [hw/dif_mon_if.sv]
`timescale 1ns/1ps
interface dif_mon_if;
  logic [dif_pkg::FREQ_W-1:0] quantity;
  logic [dif_pkg::FREQ_W-1:0] full_scale;
  logic [dif_pkg::GAIN_W-1:0] gain;
  logic [dif_pkg::DAC_W-1:0]  code;
  modport src  (output quantity, output full_scale, output gain, input code);
  modport sink (input quantity, input full_scale, input gain, output code);
endinterface

// [hw/dif_mon_scale.sv]
`timescale 1ns/1ps
module dif_mon_scale (
  input wire logic clk_sys,
  input wire logic arst_n,
  dif_mon_if.sink  mon
);

  logic [39:0] num;
  logic [39:0] den;
  logic [39:0] quo;

  // ****************************************
  // Quantity over full scale times gain/100
  // ****************************************
  always_comb begin
    num = 40'(mon.quantity) * 40'(mon.gain) * 40'(dif_pkg::DAC_FULL);
    den = 40'(mon.full_scale) * 40'(dif_pkg::GAIN_DIV);
    quo = (den == 40'h0) ? 40'h0 : num / den;
  end

  // Codes above full scale clamp at the 10 V code.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mon.code <= '0;
    end else if (quo > 40'(dif_pkg::DAC_FULL)) begin
      mon.code <= dif_pkg::DAC_FULL;
    end else begin
      mon.code <= quo[dif_pkg::DAC_W-1:0];
    end
  end

endmodule

// [tb/dif_top_props.sv]
`timescale 1ns/1ps
module dif_top_chk (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        drive_stopped,
  input wire logic        drive_stopping,
  input wire logic [7:0]  dc_injection_brake_level,
  input wire logic [15:0] max_freq,
  input wire logic        dc_injection_brake,
  input wire logic [7:0]  dc_level,
  input wire logic        motor2_sel,
  input wire logic        open_loop,
  input wire logic        drive_side_relay,
  input wire logic        line_side_relay,
  input wire logic        speed_search_setting,
  input wire logic [15:0] speed_ref,
  input wire logic        ext_fault,
  input wire logic        output_disable,
  input wire logic        output_cut,
  input wire logic        fault_clear
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence gap_s;
    (!drive_side_relay && !line_side_relay) [*8];
  endsequence
  relay_excl_a: assert property (!(drive_side_relay && line_side_relay))
    else $error("both transfer relays closed");
  gap_to_line_a: assert property ($fell(drive_side_relay) |-> gap_s)
    else $error("no open gap after drive relay opened");
  gap_to_drive_a: assert property ($fell(line_side_relay) |-> gap_s)
    else $error("no open gap after line relay opened");
  search_xchg_a: assert property ($changed(drive_side_relay) |->
    speed_search_setting != drive_side_relay) else $error("speed search out of step");
  speed_clamp_a: assert property (speed_ref <= max_freq)
    else $error("speed reference above maximum");
  stop_only_a: assert property (!drive_stopped && !$past(drive_stopped) |=>
    $stable(motor2_sel) && $stable(open_loop)) else $error("switch moved while running");
  brake_state_a: assert property (dc_injection_brake |->
    $past(drive_stopped || drive_stopping) && dc_level == dc_injection_brake_level)
    else $error("brake out of state or level");
  trip_cut_a: assert property (ext_fault || output_disable |=> output_cut)
    else $error("output not cut on latched fault");
  clear_pulse_a: assert property (fault_clear |=> !fault_clear)
    else $error("fault clear held");
endmodule
bind dif_top dif_top_chk u_chk (.*);

// [tb/dif_contacts.sv]
`timescale 1ns/1ps
module dif_contacts (
  input  wire logic       clk_sys,
  input  wire logic [7:0] press,
  input  wire logic [7:0] nc_contact,
  output logic      [7:0] term_pin
);
  // A normally-closed contact opens while its button is pressed.
  always_ff @(posedge clk_sys) begin
    term_pin <= press ^ nc_contact;
  end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic arst_n, mmc_interlock_en, drive_stopped, drive_stopping, three_wire_mode;
  logic analog_ref_sel, combo_ref_sel, dc_injection_brake, motor2_sel, drive_side_relay;
  logic line_side_relay, speed_search_setting, run_cmd, ext_fault, output_disable;
  logic output_cut, fault_clear, preheat_on, integrator_clear, open_loop, local_remote_sel;
  logic freq_freeze, ramp_hold, pgain2_sel, current_ref_sel, outer_pid_run, dup_assign;
  logic [7:0] term_pin, term_nc_mask, filter_ms, dc_injection_brake_level, preheat_level, press, nc;
  logic [7:0][4:0] term_func;
  logic [15:0] max_freq, updown_step, speed_ref;
  logic [1:0][15:0] mon_quantity, mon_full_scale;
  logic [1:0][7:0] mon_gain;
  logic [2:0] ramp_set;
  logic [7:0] dc_level;
  logic [3:0] interlock;
  logic [9:0] monitor_out_a, monitor_out_b;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int clr_cnt = 0;
  dif_top #(.CYC_PER_MS(10), .INTERLOCK_CYC(50)) DUT (.*);
  dif_contacts u_contacts (.clk_sys(clk_sys), .press(press), .nc_contact(nc),
    .term_pin(term_pin));
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic st();
    repeat (1040) @(posedge clk_sys);
  endtask
  task automatic hit(input logic [7:0] p);
    @(posedge clk_sys);
    press <= p;
    st();
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (fault_clear === 1'b1) begin
      clr_cnt <= clr_cnt + 1;
    end
    if (cyc == 50000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    arst_n = 1'b0;
    press = 8'h00;
    nc = 8'h40;
    term_nc_mask = 8'h40;
    filter_ms = 8'h65;
    term_func = {dif_pkg::FN_FAULT_RESET, dif_pkg::FN_EXT_TRIP, dif_pkg::FN_DOWN,
      dif_pkg::FN_UP, dif_pkg::FN_EXCHANGE, dif_pkg::FN_RAMP_SEL_HIGH,
      dif_pkg::FN_RAMP_SEL_MID, dif_pkg::FN_RAMP_SEL_LOW};
    {mmc_interlock_en, drive_stopping, three_wire_mode} = 3'h0;
    {drive_stopped, analog_ref_sel, combo_ref_sel} = 3'h7;
    dc_injection_brake_level = 8'h5A;
    preheat_level = 8'h21;
    max_freq = 16'h0100;
    updown_step = 16'h0060;
    mon_quantity = {16'h1000, 16'h0800};
    mon_full_scale = {16'h1000, 16'h1000};
    mon_gain = {8'hC8, 8'h64};
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    st();
    chk("boot_trip", {ext_fault, output_cut}, 16'h0000);
    chk("mon_a", monitor_out_a, 16'h01FF);
    chk("mon_b", monitor_out_b, 16'h03FF);
    for (int n = 0; n < 8; n++) begin
      hit(8'(n));
      chk("ramp_set", ramp_set, 16'(n));
    end
    @(posedge clk_sys);
    press <= 8'h08;
    for (int i = 0; i < 1100 && drive_side_relay; i++) begin
      @(posedge clk_sys);
    end
    chk("xchg_gap", {line_side_relay, speed_search_setting}, 16'h0001);
    repeat (45) @(posedge clk_sys);
    chk("line_early", line_side_relay, 16'h0000);
    repeat (10) @(posedge clk_sys);
    chk("line_on", {line_side_relay, speed_search_setting}, 16'h0003);
    hit(8'h00);
    repeat (60) @(posedge clk_sys);
    chk("xchg_back", {drive_side_relay, line_side_relay, speed_search_setting}, 16'h0004);
    for (int i = 0; i < 4; i++) begin
      hit((i < 3) ? 8'h10 : 8'h20);
      hit(8'h00);
      chk("speed_ref", speed_ref, (i < 2) ? 16'(96 * (i + 1)) : 16'(256 - 96 * (i - 2)));
    end
    hit(8'h40);
    chk("trip", {ext_fault, output_cut}, 16'h0003);
    hit(8'h00);
    chk("trip_held", ext_fault, 16'h0001);
    hit(8'h80);
    chk("trip_reset", ext_fault, 16'h0000);
    chk("clr_pulse", 16'(clr_cnt), 16'h0001);
    @(posedge clk_sys);
    term_func <= {dif_pkg::FN_RAMP_HOLD, dif_pkg::FN_ANALOG_HOLD, dif_pkg::FN_LOCAL_REMOTE,
      dif_pkg::FN_OPEN_LOOP, dif_pkg::FN_INTEG_CLEAR, dif_pkg::FN_PREHEAT,
      dif_pkg::FN_MOTOR2, dif_pkg::FN_DC_INJECTION_BRAKE};
    press <= 8'h00;
    nc <= 8'h00;
    term_nc_mask <= 8'h00;
    hit(8'hFF);
    chk("levels", {dc_injection_brake, motor2_sel, preheat_on, integrator_clear, open_loop,
      local_remote_sel, freq_freeze, ramp_hold}, 16'h00FF);
    chk("dc_level", dc_level, 16'h005A);
    @(posedge clk_sys);
    drive_stopped <= 1'b0;
    hit(8'h04);
    chk("frozen", {dc_injection_brake, motor2_sel, preheat_on, open_loop}, 16'h0007);
    chk("dc_preheat", dc_level, 16'h0021);
    @(posedge clk_sys);
    drive_stopped <= 1'b1;
    st();
    chk("tracked", {motor2_sel, open_loop}, 16'h0000);
    @(posedge clk_sys);
    term_func <= {dif_pkg::FN_PGAIN2, dif_pkg::FN_FAULT_RESET, dif_pkg::FN_THREE_WIRE,
      dif_pkg::FN_FORWARD_RUN, dif_pkg::FN_OUTER_PID_RUN, dif_pkg::FN_ANA_CHANGE,
      dif_pkg::FN_OUT_DISABLE, dif_pkg::FN_PGAIN2};
    nc <= 8'h20;
    three_wire_mode <= 1'b1;
    hit(8'h0F);
    chk("dup", dup_assign, 16'h0001);
    chk("pid", {pgain2_sel, current_ref_sel, outer_pid_run, output_disable}, 16'h000F);
    hit(8'h00);
    chk("pid_off", {pgain2_sel, current_ref_sel, outer_pid_run, output_disable}, 16'h0001);
    hit(8'h40);
    chk("dis_reset", output_disable, 16'h0000);
    hit(8'h10);
    hit(8'h00);
    chk("run_latch", run_cmd, 16'h0001);
    hit(8'h20);
    chk("run_stop", run_cmd, 16'h0000);
    @(posedge clk_sys);
    mmc_interlock_en <= 1'b1;
    hit(8'h0F);
    chk("interlock", {interlock, pgain2_sel, output_disable}, 16'h003C);
    chk("clr_pulses", 16'(clr_cnt), 16'h0002);
    test_done();
  end
endmodule
